// ---- verilog/urx_pkg.sv ----
package urx_pkg;
  // Status byte field positions
  localparam int URX_LS_LO = 0;
  localparam int URX_LS_HI = 1;
  localparam int URX_VB_LO = 2;
  localparam int URX_VB_HI = 3;
  localparam int URX_EV_LO = 4;
  localparam int URX_EV_HI = 5;
  localparam int URX_ID_BIT = 6;
  localparam int URX_ALT_BIT = 7;
  // Encoded VBUS levels
  localparam logic [1:0] URX_VB_END = 2'h0;
  localparam logic [1:0] URX_VB_LOW = 2'h1;
  localparam logic [1:0] URX_VB_SESS = 2'h2;
  localparam logic [1:0] URX_VB_VALID = 2'h3;
  // Encoded receive events
  localparam logic [1:0] URX_EV_IDLE = 2'h0;
  localparam logic [1:0] URX_EV_ACTIVE = 2'h1;
  localparam logic [1:0] URX_EV_ERROR = 2'h3;
  localparam logic [1:0] URX_EV_DISC = 2'h2;
  // Line states
  localparam logic [1:0] URX_LS_SE0 = 2'h0;
  localparam logic [1:0] URX_LS_SE1 = 2'h3;
  // Send scheduler states
  typedef enum logic [2:0] {
    URX_ST_IDLE = 3'h1,
    URX_ST_PEND = 3'h2,
    URX_ST_SEND = 3'h4
  } urx_state_type;
endpackage : urx_pkg

// ---- verilog/urx_sync3.sv ----
`timescale 1ns/1ps
// Three-stage synchroniser; output moves when stages two and three agree
module urx_sync3 import urx_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_r, s2_r, s3_r, out_r;
  logic [WIDTH-1:0] out_nxt;

  // Per-bit agreement filter
  always_comb begin
    out_nxt = out_r;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        out_nxt[i] = s3_r[i];
      end
    end
  end

  // Registers only
  always_ff @(posedge mclk) begin
    if (reset) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      out_r <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end
  assign dout = out_r;
endmodule : urx_sync3

// ---- verilog/urx_status_encoder.sv ----
`timescale 1ns/1ps
module urx_status_encoder import urx_pkg::*; (
  input wire logic mclk,
  input wire logic reset,
  input wire logic fs_dp_rx,
  input wire logic fs_dm_rx,
  input wire logic session_end_flag,
  input wire logic session_valid_flag,
  input wire logic vbus_valid_flag,
  input wire logic rx_active,
  input wire logic rx_error,
  input wire logic host_disconnect_flag,
  input wire logic id_pin,
  input wire logic carkit_int_pending,
  input wire logic dir_in,
  input wire logic nxt_in,
  output logic [7:0] status_byte,
  output logic status_send,
  output logic line_se0,
  output logic line_se1
);
  ////////////////////////////////////////////////////////////////////////
  // Pin inputs cross into mclk
  logic [1:0] line_s;   // Filtered D+/D-
  logic [2:0] vb_s;     // Filtered comparators
  logic id_s;           // Filtered ID level

  urx_sync3 #(.WIDTH(6)) u_sync (
    .mclk(mclk),
    .reset(reset),
    .din({id_pin, vbus_valid_flag, session_valid_flag, session_end_flag,
          fs_dm_rx, fs_dp_rx}),
    .dout({id_s, vb_s, line_s})
  );

  // VBUS level encoding, highest comparator first
  function automatic logic [1:0] enc_vbus(input logic [2:0] v);
    if (v[2]) enc_vbus = URX_VB_VALID;
    else if (v[1]) enc_vbus = URX_VB_SESS;
    else if (v[0]) enc_vbus = URX_VB_END;
    else enc_vbus = URX_VB_LOW;
  endfunction : enc_vbus

  // Receive event encoding; disconnect overrides everything
  function automatic logic [1:0] enc_event(input logic act,
                                           input logic err,
                                           input logic disc);
    if (disc) enc_event = URX_EV_DISC;
    else if (act && err) enc_event = URX_EV_ERROR;
    else if (act) enc_event = URX_EV_ACTIVE;
    else enc_event = URX_EV_IDLE;
  endfunction : enc_event

  ////////////////////////////////////////////////////////////////////////
  // Status byte snapshot
  logic [7:0] byte_r, byte_nxt;
  logic [1:0] prev_line_r, prev_line_nxt;
  logic [2:0] prev_vb_r, prev_vb_nxt;
  logic prev_id_r, prev_id_nxt;
  logic se0_r, se0_nxt, se1_r, se1_nxt;

  // One consistent sample of every field per clock
  always_comb begin
    byte_nxt = 8'h00;
    byte_nxt[URX_LS_LO] = line_s[0];
    byte_nxt[URX_LS_HI] = line_s[1];
    byte_nxt[URX_VB_HI:URX_VB_LO] = enc_vbus(vb_s);
    byte_nxt[URX_EV_HI:URX_EV_LO] =
      enc_event(rx_active, rx_error, host_disconnect_flag);
    byte_nxt[URX_ID_BIT] = id_s;
    // Carkit latch feeds this; ID/conversion events arrive through it
    byte_nxt[URX_ALT_BIT] = carkit_int_pending;
    se0_nxt = (line_s == URX_LS_SE0);
    se1_nxt = (line_s == URX_LS_SE1);
    prev_line_nxt = line_s;
    prev_vb_nxt = vb_s;
    prev_id_nxt = id_s;
  end

  // Registers only
  always_ff @(posedge mclk) begin
    if (reset) begin
      byte_r <= 8'h00;
      prev_line_r <= 2'h0;
      prev_vb_r <= 3'h0;
      prev_id_r <= 1'h0;
      se0_r <= 1'h1; // Reset byte shows a zero line state
      se1_r <= 1'h0;
    end else begin
      byte_r <= byte_nxt;
      prev_line_r <= prev_line_nxt;
      prev_vb_r <= prev_vb_nxt;
      prev_id_r <= prev_id_nxt;
      se0_r <= se0_nxt;
      se1_r <= se1_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Send scheduling; a change while the bus is busy waits as pending
  logic line_chg, cmp_chg, rx_slot;
  urx_state_type st_r, st_nxt;
  logic send_r, send_nxt;

  assign line_chg = (line_s != prev_line_r);
  assign cmp_chg = (vb_s != prev_vb_r) || (id_s != prev_id_r);
  assign rx_slot = dir_in && !nxt_in && rx_active;

  // Next state and send strobe
  always_comb begin
    st_nxt = st_r;
    send_nxt = 1'b0;
    case (st_r)
      URX_ST_IDLE, URX_ST_SEND: begin
        if (rx_slot) begin
          send_nxt = 1'b1;
          st_nxt = URX_ST_SEND;
        end else if (line_chg || cmp_chg) begin
          if (!dir_in) begin
            send_nxt = 1'b1;
            st_nxt = URX_ST_SEND;
          end else begin
            st_nxt = URX_ST_PEND;
          end
        end else begin
          st_nxt = URX_ST_IDLE;
        end
      end
      URX_ST_PEND: begin
        // Held change goes out once the bus frees or a slot opens
        if (!dir_in || rx_slot) begin
          send_nxt = 1'b1;
          st_nxt = URX_ST_SEND;
        end
      end
      default: begin
        st_nxt = URX_ST_IDLE;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= URX_ST_IDLE;
      send_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      send_r <= send_nxt;
    end
  end

  assign status_byte = byte_r;
  assign status_send = send_r;
  assign line_se0 = se0_r;
  assign line_se1 = se1_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Reset values of byte and SE flags agree, so the first edge is clean

  line_dp_a: assert property (byte_r[URX_LS_LO] == $past(line_s[0]))
    else $error("dp bit wrong");
  line_dm_a: assert property (byte_r[URX_LS_HI] == $past(line_s[1]))
    else $error("dm bit wrong");
  se_flags_a: assert property (
    se0_r == (byte_r[URX_LS_HI:URX_LS_LO] == URX_LS_SE0) &&
    se1_r == (byte_r[URX_LS_HI:URX_LS_LO] == URX_LS_SE1))
    else $error("se flags wrong");
  vbus_top_a: assert property ($past(vb_s[2]) |->
    byte_r[URX_VB_HI:URX_VB_LO] == URX_VB_VALID)
    else $error("vbus code wrong");
  vbus_end_a: assert property ($past(vb_s == 3'h1) |->
    byte_r[URX_VB_HI:URX_VB_LO] == URX_VB_END)
    else $error("sess end code wrong");
  disc_wins_a: assert property ($past(host_disconnect_flag) |->
    byte_r[URX_EV_HI:URX_EV_LO] == URX_EV_DISC)
    else $error("disconnect not encoded");
  rx_err_a: assert property ($past(rx_active && rx_error &&
    !host_disconnect_flag) |-> byte_r[URX_EV_HI:URX_EV_LO] == URX_EV_ERROR)
    else $error("rx error not encoded");
  id_bit_a: assert property (byte_r[URX_ID_BIT] == $past(id_s))
    else $error("id bit wrong");
  alt_bit_a: assert property (byte_r[URX_ALT_BIT] ==
    $past(carkit_int_pending))
    else $error("alt bit wrong");
  line_send_a: assert property ((line_chg && !dir_in) |=> send_r)
    else $error("line change not sent");
  rx_send_a: assert property (rx_slot |=> send_r)
    else $error("rx slot not used");
  cmp_send_a: assert property ((cmp_chg && !dir_in) |=> send_r)
    else $error("comparator change not sent");
  busy_hold_a: assert property (
    ((line_chg || cmp_chg) && dir_in && !rx_slot) |=> st_r == URX_ST_PEND)
    else $error("busy change not held");
  pend_quiet_a: assert property (
    (st_r == URX_ST_PEND && dir_in && !rx_slot) |=> !send_r)
    else $error("pending byte sent while busy");
  pend_free_a: assert property (
    (st_r == URX_ST_PEND && !dir_in) |=> send_r)
    else $error("pending byte not sent");

  line_send_c: cover property (line_chg && !dir_in ##1 send_r);
  pend_c: cover property (st_r == URX_ST_PEND ##[1:20] send_r);
  rx_c: cover property (rx_slot [*3]);
  cmp_send_c: cover property (cmp_chg && !dir_in ##1 send_r);
endmodule : urx_status_encoder

// ---- test/urx_link_model.sv ----
`timescale 1ns/1ps
// Link controller stand-in: takes each announced status byte
module urx_link_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] status_byte,
  input wire logic status_send,
  output logic [7:0] last_byte_r, // Last byte taken
  output logic [7:0] send_count_r, // Bytes taken so far
  output logic [7:0] alt_reads_r // Latch reads issued
);
  // Byte is taken on the announcing edge only; a stale byte is ignored
  always_ff @(posedge mclk) begin
    if (reset) begin
      last_byte_r <= 8'h00;
      send_count_r <= 8'h00;
      alt_reads_r <= 8'h00;
    end else if (status_send) begin
      last_byte_r <= status_byte;
      send_count_r <= send_count_r + 8'h01;
      // Alt flag seen, so the latch register gets read
      if (status_byte[7]) alt_reads_r <= alt_reads_r + 8'h01;
    end
  end
endmodule : urx_link_model

// ---- test/ulpi_rxcmd_status_encoder_bench.sv ----
`timescale 1ns/1ps
module ulpi_rxcmd_status_encoder_bench;
  logic mclk = 0, reset = 1, fs_dp_rx = 0, fs_dm_rx = 0;
  logic session_end_flag = 0, session_valid_flag = 0, vbus_valid_flag = 0;
  logic rx_active = 0, rx_error = 0, host_disconnect_flag = 0, id_pin = 0;
  logic carkit_int_pending = 0, dir_in = 0, nxt_in = 0;
  logic [7:0] status_byte, last_byte, send_count, alt_reads, n;
  logic status_send, line_se0, line_se1;
  int failures = 0, compares = 0, cyc = 0;
  // 100 MHz clock
  always #5 mclk = ~mclk;
  urx_status_encoder DUT (.mclk(mclk), .reset(reset), .fs_dp_rx(fs_dp_rx),
    .fs_dm_rx(fs_dm_rx), .session_end_flag(session_end_flag),
    .session_valid_flag(session_valid_flag),
    .vbus_valid_flag(vbus_valid_flag), .rx_active(rx_active),
    .rx_error(rx_error), .host_disconnect_flag(host_disconnect_flag),
    .id_pin(id_pin), .carkit_int_pending(carkit_int_pending),
    .dir_in(dir_in), .nxt_in(nxt_in), .status_byte(status_byte),
    .status_send(status_send), .line_se0(line_se0), .line_se1(line_se1));
  urx_link_model link (.mclk(mclk), .reset(reset), .status_byte(status_byte),
    .status_send(status_send), .last_byte_r(last_byte),
    .send_count_r(send_count), .alt_reads_r(alt_reads));
  ////////////////////////////////////////////////////////////////////////
  // Drive just after the edge so sampling never races the bench
  task tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : tick
  task check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task give_verdict;
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////
  // Every line state, including both single-ended states
  task t_line;
    for (int i = 1; i < 5; i++) begin
      n = send_count;
      {fs_dm_rx, fs_dp_rx} = i[1:0];
      tick(6); // Filter plus byte register
      check(status_byte[1:0], i[1:0]);
      check({line_se1, line_se0}, {i[1:0] == 2'h3, i[1:0] == 2'h0});
      check(send_count != n, 8'h01);
    end
  endtask : t_line
  // Comparator table, last step changes flags but not the code
  task automatic t_vbus;
    logic [2:0] v[5] = '{3'h4, 3'h0, 3'h2, 3'h7, 3'h1};
    logic [1:0] e[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    for (int i = 0; i < 5; i++) begin
      n = send_count;
      {session_end_flag, session_valid_flag, vbus_valid_flag} = v[i];
      tick(6);
      check(status_byte[3:2], e[i]);
      check(send_count != n, 8'h01);
    end
  endtask : t_vbus
  // Receive events; disconnect wins over the rest
  task automatic t_event;
    logic [2:0] v[5] = '{3'h4, 3'h6, 3'h7, 3'h1, 3'h0};
    logic [1:0] e[5] = '{2'h1, 2'h3, 2'h2, 2'h2, 2'h0};
    for (int i = 0; i < 5; i++) begin
      {rx_active, rx_error, host_disconnect_flag} = v[i];
      tick(2);
      check(status_byte[5:4], e[i]);
    end
  endtask : t_event
  // ID level both ways, then an ID change with the alt flag raised
  task t_id;
    for (int i = 1; i < 4; i++) begin
      n = send_count;
      id_pin = i[0];
      carkit_int_pending = (i == 3);
      tick(6);
      check(status_byte[6], i[0]);
      check(send_count != n, 8'h01);
    end
    check(status_byte[7], 8'h01);
    check(last_byte[7], 8'h01);
    check(alt_reads != 8'h00, 8'h01);
    carkit_int_pending = 0;
    tick(2);
    check(status_byte[7], 8'h00);
  endtask : t_id
  // Line change while busy is held, then leaves in the receive slot
  task t_slot;
    dir_in = 1;
    nxt_in = 1;
    n = send_count;
    fs_dp_rx = 1;
    tick(8);
    check(send_count, n);
    nxt_in = 0;
    rx_active = 1;
    // Slot held three cycles: a byte leaves in each
    for (int k = 0; k < 3; k++) begin
      tick(1);
      check(status_send, 8'h01);
    end
    check(status_byte[5:4], 8'h01);
    check(status_byte[0], 8'h01);
    // Busy again: a D- change waits until the bus frees
    nxt_in = 1;
    rx_active = 0;
    fs_dm_rx = 1;
    tick(1);
    n = send_count;
    tick(7);
    check(send_count, n);
    dir_in = 0;
    tick(1);
    check(status_send, 8'h01);
    check(line_se1, 8'h01);
    tick(3);
  endtask : t_slot
  ////////////////////////////////////////////////////////////////////////
  // Hang guard; the whole run needs under 140 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      give_verdict;
    end
  end
  // Main sequence
  initial begin
    tick(20);
    reset = 0;
    tick(6);
    t_line;
    t_vbus;
    t_event;
    t_id;
    t_slot;
    give_verdict;
  end
endmodule : ulpi_rxcmd_status_encoder_bench
